//--- rtl/pic_pkg.sv
// Package: port addresses, command word fields and reset values of the interrupt controller
package pic_pkg;

	// ---------------------------------------------------------------
	// Port addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] PIC_PORT_LOW  = 8'h20; // Command / readback port
	localparam logic [7:0] PIC_PORT_HIGH = 8'h21; // Mask / init data port

	// ---------------------------------------------------------------
	// Command word field positions
	// ---------------------------------------------------------------
	localparam int INIT_FIRST_FLAG_BIT  = 4; // Marks the first init word
	localparam int INIT_LEVEL_TRIG_BIT  = 3; // Level (1) / edge (0)
	localparam int INIT_INTERVAL_BIT    = 2; // Call interval 4 (1) / 8 (0)
	localparam int INIT_SINGLE_BIT      = 1; // Single (1) / cascade (0)
	localparam int INIT_NEED_FOURTH_BIT = 0; // Fourth word follows
	localparam int MODE_NESTED_BIT      = 4; // Special fully nested
	localparam int MODE_BUFFERED_BIT    = 3; // Buffered operation
	localparam int MODE_MASTER_BIT      = 2; // Master role when buffered
	localparam int MODE_AUTO_EOI_BIT    = 1; // Automatic end of interrupt
	localparam int OP_ROTATE_BIT        = 7; // Rotate command bit
	localparam int OP_SPECIFIC_BIT      = 6; // specific_level_bit
	localparam int OP_EOI_BIT           = 5; // end_of_service_bit
	localparam int OP_SEL3_BIT          = 3; // Selects third operation word
	localparam int OP_MASK_CHG_BIT      = 6; // special_mask_change_enable
	localparam int OP_MASK_SEL_BIT      = 5; // special_mask_select
	localparam int OP_POLL_BIT          = 2; // Poll command
	localparam int OP_RDSEL_EN_BIT      = 1; // readback_select_enable
	localparam int OP_RD_ISR_BIT        = 0; // readback_in_service_select
	localparam int TYPE_LOW_BIT         = 3; // Lowest programmed type bit

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] MASK_RESET = 8'hff; // All levels inhibited
	localparam logic [7:0] BYTE_ZERO  = 8'h00;

	// Initialisation sequencer states
	typedef enum logic [3:0] {
		SEQ_READY  = 4'h1,
		SEQ_TYPE   = 4'h2,
		SEQ_CASC   = 4'h4,
		SEQ_FOURTH = 4'h8
	} pic_seq_type;

endpackage

//--- rtl/pic_prio.sv
// Priority resolver: lowest-numbered set bit after rotation by a base level
`timescale 1ns/100ps
`default_nettype none
module pic_prio
	import pic_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Inputs
	input  wire logic [WIDTH-1:0]         bits,
	input  wire logic [$clog2(WIDTH)-1:0] base,
	// Result
	output logic                          found,
	output logic [$clog2(WIDTH)-1:0]      level
);
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	if (WIDTH != 8) begin : g_bad
		$error("pic_prio supports only WIDTH 8");
	end

	// ---------------------------------------------------------------
	// Search
	// ---------------------------------------------------------------
	// Scan from base+7 down to base, wrapping; last hit, nearest base, is highest priority
	always_comb begin
		logic [$clog2(WIDTH)-1:0] idx;
		idx = '0;
		found = 1'b0;
		level = '0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			idx = base + i[$clog2(WIDTH)-1:0];
			if (bits[idx]) begin
				found = 1'b1;
				level = idx;
			end
		end
	end
endmodule
`default_nettype wire

//--- rtl/pic_core.sv
// Eight-level priority interrupt controller with port-mapped command words
//
// Functional notes
// - Low port, bit4 set: first init word
// - First word: trigger, interval, cascade, fourth-word
// - Second word loads type bits 7..3
// - Acknowledge drives type bits plus level
// - Third init word only when cascaded
// - Fourth word: nested, buffered, master, auto-END_OF_SERVICE_BIT
// - High port after init loads mask
// - Low port bits4,3 zero: second operation word
// - Specific bit applies command to level bits
// - Bit7,4 zero, bit3 set: third word; poll
// - Special mask mode changes only with enable
// - Register select chooses in-service or request readback
`timescale 1ns/100ps
`default_nettype none
module pic_core
	import pic_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Host I/O port access
	input  wire logic [7:0] ioAddr,
	input  wire logic       ioWrite,
	input  wire logic       ioRead,
	input  wire logic [7:0] ioWrData,
	output logic      [7:0] ioRdData,
	// Interrupt acknowledge
	input  wire logic       intAck,
	output logic      [7:0] ackData,
	output logic            ackValid,
	// Request inputs and processor interrupt
	input  wire logic [7:0] requestInputLevel,
	output logic            intReq,
	// Mode status
	output logic            fourByteInterval,
	output logic            bufferedMode,
	output logic            masterRole
);
	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic        wrLow;      // Write to low port
	logic        wrHigh;     // Write to high port
	logic        isFirst;    // First init word
	logic        isOpTwo;    // Second operation word
	logic        isOpThree;  // Third operation word
	assign wrLow     = ioWrite && ioAddr == PIC_PORT_LOW;
	assign wrHigh    = ioWrite && ioAddr == PIC_PORT_HIGH;
	assign isFirst   = wrLow && ioWrData[INIT_FIRST_FLAG_BIT];
	assign isOpTwo   = wrLow && !ioWrData[INIT_FIRST_FLAG_BIT]
		&& !ioWrData[OP_SEL3_BIT];
	assign isOpThree = wrLow && !ioWrData[7] && !ioWrData[INIT_FIRST_FLAG_BIT]
		&& ioWrData[OP_SEL3_BIT];

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	pic_seq_type seq;          // Init sequencer
	logic        levelTrig;    // Level (1) / edge (0) triggering
	logic        singleMode;   // No cascade word expected
	logic        needFourth;   // Fourth word expected
	logic        nestedMode;   // Special fully nested
	logic        autoEoi;      // Auto end of interrupt on acknowledge
	logic [4:0]  typeBits;     // Programmed vector type bits
	logic [7:0]  cascadeMap;   // Slave map or slave identity
	logic [7:0]  levelMask;    // One inhibits a level
	logic [7:0]  inService;    // Levels being serviced
	logic [7:0]  request;      // Latched requests
	logic [7:0]  reqPrev;      // Previous inputs for edge detect
	logic [2:0]  prioBase;     // Highest priority level (rotation)
	logic        specialMask;  // Special mask mode
	logic        readIsr;      // Readback selects in-service
	logic        pollPending;  // Next low read returns poll byte

	// ---------------------------------------------------------------
	// Priority resolution
	// ---------------------------------------------------------------
	logic [7:0]  pending;      // Unmasked requests
	logic [7:0]  isrSeen;      // In-service levels that block others
	logic        reqFound;
	logic [2:0]  reqLevel;
	logic        isrFound;
	logic [2:0]  isrLevel;
	logic        serviceable;  // A request beats every in-service level
	assign pending = request & ~levelMask;
	// Special mask mode lets masked in-service levels stop blocking
	assign isrSeen = specialMask ? (inService & ~levelMask) : inService;

	pic_prio #(.WIDTH(8)) uReqPrio (
		.bits  (pending),
		.base  (prioBase),
		.found (reqFound),
		.level (reqLevel)
	);
	pic_prio #(.WIDTH(8)) uIsrPrio (
		.bits  (isrSeen),
		.base  (prioBase),
		.found (isrFound),
		.level (isrLevel)
	);

	// Priority distance from the base; zero is the highest
	logic [2:0] reqRank;
	logic [2:0] isrRank;
	assign reqRank = reqLevel - prioBase;
	assign isrRank = isrLevel - prioBase;
	// Nested mode lets an in-service level be re-entered by itself
	assign serviceable = reqFound && (!isrFound || reqRank < isrRank
		|| (nestedMode && reqRank == isrRank));

	// ---------------------------------------------------------------
	// Initialisation sequencer and mode bits
	// ---------------------------------------------------------------
	// A new first word always restarts, so a lost sequence recovers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq        <= SEQ_TYPE;
			levelTrig  <= 1'b0;
			fourByteInterval <= 1'b0;
			singleMode <= 1'b1;
			needFourth <= 1'b0;
			typeBits   <= 5'h00;
			cascadeMap <= BYTE_ZERO;
			nestedMode <= 1'b0;
			bufferedMode <= 1'b0;
			masterRole <= 1'b0;
			autoEoi    <= 1'b0;
		end else if (isFirst) begin
			levelTrig  <= ioWrData[INIT_LEVEL_TRIG_BIT];
			fourByteInterval <= ioWrData[INIT_INTERVAL_BIT];
			singleMode <= ioWrData[INIT_SINGLE_BIT];
			needFourth <= ioWrData[INIT_NEED_FOURTH_BIT];
			nestedMode <= 1'b0;
			bufferedMode <= 1'b0;
			autoEoi    <= 1'b0;
			seq        <= SEQ_TYPE;
		end else if (wrHigh) begin
			unique case (seq)
				SEQ_TYPE: begin
					typeBits <= ioWrData[7:TYPE_LOW_BIT];
					if (!singleMode)
						seq <= SEQ_CASC;
					else if (needFourth)
						seq <= SEQ_FOURTH;
					else
						seq <= SEQ_READY;
				end
				SEQ_CASC: begin
					cascadeMap <= ioWrData;
					seq <= needFourth ? SEQ_FOURTH : SEQ_READY;
				end
				SEQ_FOURTH: begin
					nestedMode   <= ioWrData[MODE_NESTED_BIT];
					bufferedMode <= ioWrData[MODE_BUFFERED_BIT];
					// Role bit only means something when buffered
					masterRole   <= ioWrData[MODE_BUFFERED_BIT]
						& ioWrData[MODE_MASTER_BIT];
					autoEoi      <= ioWrData[MODE_AUTO_EOI_BIT];
					seq <= SEQ_READY;
				end
				SEQ_READY: begin
					// Mask writes handled below
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Mask register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			levelMask <= MASK_RESET;
		else if (isFirst)
			levelMask <= BYTE_ZERO;
		else if (wrHigh && seq == SEQ_READY)
			levelMask <= ioWrData;
	end

	// ---------------------------------------------------------------
	// Third operation word: special mask, readback select, poll
	// ---------------------------------------------------------------
	logic opReady;
	assign opReady = seq == SEQ_READY;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			specialMask <= 1'b0;
			readIsr     <= 1'b0;
			pollPending <= 1'b0;
		end else if (isFirst) begin
			specialMask <= 1'b0;
			readIsr     <= 1'b0;
			pollPending <= 1'b0;
		end else if (isOpThree && opReady) begin
			if (ioWrData[OP_MASK_CHG_BIT])
				specialMask <= ioWrData[OP_MASK_SEL_BIT];
			if (ioWrData[OP_RDSEL_EN_BIT])
				readIsr <= ioWrData[OP_RD_ISR_BIT];
			pollPending <= ioWrData[OP_POLL_BIT];
		end else if (ioRead && ioAddr == PIC_PORT_LOW) begin
			pollPending <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Request latch
	// ---------------------------------------------------------------
	// Edge mode holds a request until acknowledged; level mode follows
	logic       takeLevel;  // Level granted this cycle
	logic [7:0] takeMask;
	assign takeLevel = (intAck && ackValid == 1'b0 && serviceable)
		|| (pollPending && ioRead && ioAddr == PIC_PORT_LOW && serviceable);
	assign takeMask  = takeLevel ? (8'h01 << reqLevel) : BYTE_ZERO;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			request <= BYTE_ZERO;
			reqPrev <= BYTE_ZERO;
		end else begin
			reqPrev <= requestInputLevel;
			if (levelTrig)
				request <= requestInputLevel & ~takeMask;
			else
				// New edge wins over the clear from an acknowledge
				request <= (request & ~takeMask)
					| (requestInputLevel & ~reqPrev);
		end
	end

	// ---------------------------------------------------------------
	// In-service register and rotation
	// ---------------------------------------------------------------
	logic [2:0] eoiLevel;   // Level an end-of-interrupt acts on
	logic [7:0] eoiMask;
	logic       doEoi;
	assign eoiLevel = ioWrData[OP_SPECIFIC_BIT] ? ioWrData[2:0] : isrLevel;
	assign doEoi    = isOpTwo && opReady && ioWrData[OP_EOI_BIT]
		&& (ioWrData[OP_SPECIFIC_BIT] || isrFound);
	assign eoiMask  = doEoi ? (8'h01 << eoiLevel) : BYTE_ZERO;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inService <= BYTE_ZERO;
			prioBase  <= 3'h0;
		end else if (isFirst) begin
			inService <= BYTE_ZERO;
			prioBase  <= 3'h0;
		end else begin
			// Auto-END_OF_SERVICE_BIT never records the level as in service
			inService <= (inService & ~eoiMask)
				| (autoEoi ? BYTE_ZERO : takeMask);
			if (isOpTwo && opReady && ioWrData[OP_ROTATE_BIT]) begin
				if (ioWrData[OP_SPECIFIC_BIT])
					prioBase <= ioWrData[2:0] + 3'h1;
				else if (doEoi)
					prioBase <= eoiLevel + 3'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupt output and acknowledge byte
	// ---------------------------------------------------------------
	// ackValid marks the first acknowledge cycle; a held intAck yields again every second cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			intReq   <= 1'b0;
			ackData  <= BYTE_ZERO;
			ackValid <= 1'b0;
		end else begin
			intReq   <= serviceable && opReady && !takeLevel;
			ackValid <= intAck && !ackValid;
			if (intAck && !ackValid)
				ackData <= {typeBits, reqLevel};
		end
	end

	// ---------------------------------------------------------------
	// Readback
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ioRdData <= BYTE_ZERO;
		else if (ioRead && ioAddr == PIC_PORT_HIGH)
			ioRdData <= levelMask;
		else if (ioRead && ioAddr == PIC_PORT_LOW) begin
			if (pollPending)
				ioRdData <= {serviceable, 4'h0, reqLevel};
			else
				ioRdData <= readIsr ? inService : request;
		end
	end
endmodule
`default_nettype wire

//--- verif/pic_core_props.sv
// Checker: port-level properties of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pic_core_props
	import pic_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// Host side
	input wire logic [7:0] ioAddr,
	input wire logic       ioWrite,
	input wire logic       ioRead,
	input wire logic [7:0] ioWrData,
	input wire logic [7:0] ioRdData,
	// Acknowledge, requests, mode
	input wire logic       intAck,
	input wire logic [7:0] ackData,
	input wire logic       ackValid,
	input wire logic [7:0] requestInputLevel,
	input wire logic       intReq,
	input wire logic       fourByteInterval,
	input wire logic       bufferedMode,
	input wire logic       masterRole
);
	// --------
	// Shadow of the init sequence
	// --------
	logic [1:0] seq;      // 0 done, 1 type, 2 cascade, 3 fourth
	logic       needCasc; // Cascade word expected
	logic       needFour; // Fourth word expected
	logic [7:0] mask;     // Predicted mask
	logic [7:0] typeW;    // Predicted type word
	wire lowWr = ioWrite && ioAddr == PIC_PORT_LOW;
	wire highWr = ioWrite && ioAddr == PIC_PORT_HIGH;
	// High-port writes mean init words until the sequence ends, mask after
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq <= 2'd1;
			needCasc <= 1'b0;
			needFour <= 1'b0;
			mask <= MASK_RESET;
			typeW <= BYTE_ZERO;
		end else if (lowWr && ioWrData[INIT_FIRST_FLAG_BIT]) begin
			seq <= 2'd1;
			needCasc <= !ioWrData[INIT_SINGLE_BIT];
			needFour <= ioWrData[INIT_NEED_FOURTH_BIT];
			mask <= BYTE_ZERO;
		end else if (highWr) begin
			case (seq)
				2'd0: mask <= ioWrData;
				2'd1: begin
					typeW <= ioWrData;
					seq <= needCasc ? 2'd2 : (needFour ? 2'd3 : 2'd0);
				end
				2'd2: seq <= needFour ? 2'd3 : 2'd0;
				default: seq <= 2'd0;
			endcase
		end
	end
	AST_ACK_RISE: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(intAck) |=> ackValid) else $error("acknowledge not answered");
	AST_ACK_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
		ackValid |=> !ackValid) else $error("ack valid longer than one cycle");
	AST_TYPE_ACK: assert property (@(posedge clk) disable iff (!arst_n)
		ackValid && seq == 2'd0 |-> ackData[7:3] == typeW[7:3]) else $error("type bits wrong");
	AST_RD_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		!ioRead |=> $stable(ioRdData)) else $error("read data changed without read");
	AST_MASK_READ: assert property (@(posedge clk) disable iff (!arst_n)
		ioRead && ioAddr == PIC_PORT_HIGH |=> ioRdData == $past(mask)) else $error("mask read");
	AST_MASKED_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
		(seq == 2'd0 && mask == MASK_RESET) [*3] |-> !intReq) else $error("masked interrupt");
	AST_INTERVAL: assert property (@(posedge clk) disable iff (!arst_n)
		lowWr && ioWrData[INIT_FIRST_FLAG_BIT] |=>
		fourByteInterval == $past(ioWrData[INIT_INTERVAL_BIT])) else $error("interval bit");
	AST_BUFFERED: assert property (@(posedge clk) disable iff (!arst_n)
		highWr && seq == 2'd3 |=>
		bufferedMode == $past(ioWrData[MODE_BUFFERED_BIT])) else $error("buffered bit");
endmodule
bind pic_core pic_core_props u_props (.clk(clk), .arst_n(arst_n), .ioAddr(ioAddr),
	.ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
	.intAck(intAck), .ackData(ackData), .ackValid(ackValid),
	.requestInputLevel(requestInputLevel), .intReq(intReq),
	.fourByteInterval(fourByteInterval), .bufferedMode(bufferedMode), .masterRole(masterRole));
`default_nettype wire

//--- verif/pic_host_model.sv
// Host model: port cycles and interrupt acknowledge toward the controller
`timescale 1ns/100ps
`default_nettype none
module pic_host_model
	import pic_pkg::*;
(
	// Clock and answers
	input  wire logic       clk,
	input  wire logic [7:0] ioRdData,
	input  wire logic [7:0] ackData,
	input  wire logic       ackValid,
	// Host requests
	output logic      [7:0] ioAddr,
	output logic            ioWrite,
	output logic            ioRead,
	output logic      [7:0] ioWrData,
	output logic            intAck
);
	// Idle bus; address and data inverted when released so nothing stale looks valid
	initial begin
		ioAddr = 8'h00;
		ioWrite = 1'b0;
		ioRead = 1'b0;
		ioWrData = 8'h00;
		intAck = 1'b0;
	end
	// One write, strobe held across one rising edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk);
		ioAddr <= addr;
		ioWrData <= data;
		ioWrite <= 1'b1;
		@(negedge clk);
		ioWrite <= 1'b0;
		ioAddr <= ~addr;
		ioWrData <= ~data;
	endtask
	// One read; data taken a full cycle later, it holds until the next read
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(negedge clk);
		ioAddr <= addr;
		ioRead <= 1'b1;
		@(negedge clk);
		ioRead <= 1'b0;
		ioAddr <= ~addr;
		@(negedge clk);
		data = ioRdData;
	endtask
	// Acknowledge; the answer stands one cycle only, so it is taken at once
	task automatic ack(output logic valid, output logic [7:0] data);
		@(negedge clk);
		intAck <= 1'b1;
		@(negedge clk);
		valid = ackValid;
		data = ackData;
		intAck <= 1'b0;
	endtask
	// Init words in order; a stray low-port word may be slipped in to be refused
	task automatic init(input logic [7:0] first, typ, mode, stray);
		wr(PIC_PORT_LOW, first | 8'h10);
		if (stray != 8'h00) wr(PIC_PORT_LOW, stray);
		wr(PIC_PORT_HIGH, typ);
		if (!first[INIT_SINGLE_BIT]) wr(PIC_PORT_HIGH, 8'h00);
		if (first[INIT_NEED_FOURTH_BIT]) wr(PIC_PORT_HIGH, mode | 8'h01);
	endtask
endmodule
`default_nettype wire

//--- verif/priority_interrupt_controller_tb_top.sv
// Testbench: self-checking run of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_controller_tb_top
	import pic_pkg::*;
;
	// --------
	// Signals and bench state
	// --------
	logic clk, arst_n, ioWrite, ioRead, intAck, ackValid, intReq, av;
	logic fourByteInterval, bufferedMode, masterRole;
	logic [7:0] requestInputLevel, ioAddr, ioWrData, ioRdData, ackData, typeW, rdv, adv, first;
	logic [2:0] lo, hi, lv;
	int failures, samples_checked, cycles;
	pic_core DUT (.clk(clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioWrite(ioWrite),
		.ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .intAck(intAck),
		.ackData(ackData), .ackValid(ackValid), .requestInputLevel(requestInputLevel),
		.intReq(intReq), .fourByteInterval(fourByteInterval), .bufferedMode(bufferedMode),
		.masterRole(masterRole));
	pic_host_model host (.clk(clk), .ioRdData(ioRdData), .ackData(ackData),
		.ackValid(ackValid), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
		.ioWrData(ioWrData), .intAck(intAck));
	// Clock, and a ceiling far above the expected run of about two hundred cycles
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cmp8(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cmp1(input string what, input logic exp, got);
		cmp8(what, {7'h00, exp}, {7'h00, got});
	endtask
	// Expected vector: programmed type bits over the serviced level
	function automatic logic [7:0] ackExp(input logic [2:0] level);
		return {typeW[7:TYPE_LOW_BIT], level};
	endfunction
	// Request inputs high for two cycles; edge mode latches them
	task automatic pulse(input logic [7:0] bits);
		@(negedge clk);
		requestInputLevel <= bits;
		repeat (2) @(negedge clk);
		requestInputLevel <= 8'h00;
	endtask
	task automatic waitInt();
		for (int i = 0; i < 10 && intReq !== 1'b1; i++) @(negedge clk);
		cmp1("intReq", 1'b1, intReq);
	endtask
	task automatic serve(input logic [2:0] level);
		host.ack(av, adv);
		cmp1("ackValid", 1'b1, av);
		cmp8("ackData", ackExp(level), adv);
	endtask
	// --------
	// Main sequence
	// --------
	initial begin
		arst_n = 1'b0;
		requestInputLevel = 8'h00;
		failures = 0;
		samples_checked = 0;
		cycles = 0;
		rdv = 8'($urandom(94945));
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		// Single, fourth word buffered master; random interval and type word
		first = 8'h13 | {5'h00, rdv[0], 2'b00};
		typeW = 8'($urandom);
		host.init(first, typeW, 8'h0c, 8'h0b);
		cmp1("fourByteInterval", first[INIT_INTERVAL_BIT], fourByteInterval);
		cmp1("bufferedMode", 1'b1, bufferedMode);
		cmp1("masterRole", 1'b1, masterRole);
		host.rd(PIC_PORT_HIGH, rdv);
		cmp8("mask after init", BYTE_ZERO, rdv);
		// Each level alone, then non-specific end of service
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			waitInt();
			serve(i[2:0]);
			host.wr(PIC_PORT_LOW, 8'h20);
		end
		// Two levels at once: lower number first; stray word left request readback
		lo = 3'($urandom_range(0, 3));
		hi = lo + 3'($urandom_range(1, 4));
		pulse((8'h01 << lo) | (8'h01 << hi));
		waitInt();
		serve(lo);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("request register", 8'h01 << hi, rdv);
		host.wr(PIC_PORT_LOW, 8'h0b);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("in-service register", 8'h01 << lo, rdv);
		host.wr(PIC_PORT_LOW, 8'h60 | lo);
		waitInt();
		serve(hi);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("in-service after specific end", 8'h01 << hi, rdv);
		host.wr(PIC_PORT_LOW, 8'h20 | lo);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("in-service after end", BYTE_ZERO, rdv);
		// Special mask mode: a masked in-service level stops blocking
		pulse(8'h01 << lo);
		waitInt();
		serve(lo);
		host.wr(PIC_PORT_HIGH, 8'h01 << lo);
		// Select bit without its enable must leave the mode off
		host.wr(PIC_PORT_LOW, 8'h28);
		pulse(8'h01 << hi);
		repeat (3) @(negedge clk);
		cmp1("intReq without mask enable", 1'b0, intReq);
		host.wr(PIC_PORT_LOW, 8'h68);
		waitInt();
		serve(hi);
		host.wr(PIC_PORT_LOW, 8'h48);
		host.wr(PIC_PORT_HIGH, 8'h00);
		host.wr(PIC_PORT_LOW, 8'h60 | hi);
		host.wr(PIC_PORT_LOW, 8'h60 | lo);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("in-service after special mask", BYTE_ZERO, rdv);
		// All levels masked: quiet until the mask clears
		lv = 3'($urandom);
		host.wr(PIC_PORT_HIGH, 8'hff);
		host.rd(PIC_PORT_HIGH, rdv);
		cmp8("mask", 8'hff, rdv);
		pulse(8'h01 << lv);
		repeat (4) @(negedge clk);
		cmp1("intReq masked", 1'b0, intReq);
		host.wr(PIC_PORT_HIGH, 8'h00);
		waitInt();
		serve(lv);
		host.wr(PIC_PORT_LOW, 8'h20);
		// Poll: next low read reports the level and puts it in service
		host.wr(PIC_PORT_LOW, 8'h0c);
		pulse(8'h01 << lv);
		waitInt();
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("poll word", {1'b1, 4'h0, lv}, rdv);
		host.wr(PIC_PORT_LOW, 8'h0b);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("in-service after poll", 8'h01 << lv, rdv);
		// Rotation: specific rotate makes lv lowest, so the next level wins
		host.wr(PIC_PORT_LOW, 8'h20);
		host.wr(PIC_PORT_LOW, 8'hc0 | lv);
		hi = lv + 3'h1;
		pulse((8'h01 << lv) | (8'h01 << hi));
		waitInt();
		serve(hi);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("in-service after rotate", 8'h01 << hi, rdv);
		host.wr(PIC_PORT_LOW, 8'ha0);
		waitInt();
		serve(lv);
		host.wr(PIC_PORT_LOW, 8'h20);
		// Re-init: level trigger, cascade word, nested, automatic end of service
		typeW = 8'($urandom);
		host.init(8'h19, typeW, 8'h12, 8'h00);
		cmp1("bufferedMode unbuffered", 1'b0, bufferedMode);
		cmp1("masterRole unbuffered", 1'b0, masterRole);
		cmp1("fourByteInterval eight", 1'b0, fourByteInterval);
		@(negedge clk);
		requestInputLevel <= 8'h01 << lv;
		waitInt();
		@(negedge clk);
		requestInputLevel <= 8'h00;
		repeat (3) @(negedge clk);
		// Level mode forgets a request whose input drops
		cmp1("intReq after level drop", 1'b0, intReq);
		@(negedge clk);
		requestInputLevel <= 8'h01 << lv;
		waitInt();
		serve(lv);
		requestInputLevel <= 8'h00;
		host.wr(PIC_PORT_LOW, 8'h0b);
		host.rd(PIC_PORT_LOW, rdv);
		cmp8("in-service with automatic end", BYTE_ZERO, rdv);
		stop_test();
	end
endmodule
`default_nettype wire
